// ===== rtl/evec_pkg.sv
// shared constants and carriers for exception priority and vectoring
package evec_pkg;
    // ========================================================
    // vector addresses
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_ILLEGAL = 16'h0002;
    localparam logic [15:0] VEC_STACK_ERR = 16'h0004;
    localparam logic [15:0] VEC_RESERVED = 16'h0006;
    localparam logic [15:0] VEC_SW_TRAP = 16'h0008;
    localparam int NSRC = 19;
    localparam logic [15:0] VEC_TABLE [NSRC] = '{
        16'h000A, 16'h000C, 16'h000E, 16'h002C, 16'h0024, 16'h0026,
        16'h0028, 16'h002A, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
        16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0020, 16'h0022,
        16'h002E};
    localparam logic [4:0] SRC_HOST_CMD = 5'h03;
    localparam logic [5:0] HC_DEFAULT_SLOT = 6'h16;
    localparam logic [5:0] HC_ALT_FIRST = 6'h18;
    // ========================================================
    // priority register field positions
    localparam int F_PIN1_LVL = 0;
    localparam int F_PIN1_TRIG = 2;
    localparam int F_PIN2_LVL = 3;
    localparam int F_PIN2_TRIG = 5;
    localparam int F_SER0_LVL = 8;
    localparam int F_SER1_LVL = 10;
    localparam int F_TMR_LVL = 12;
    localparam int F_HOST_LVL = 14;
    localparam int F_CODEC_LVL = 0;
    localparam int F_PIN3_EN = 4;
    localparam int F_PIN3_TRIG = 5;
    localparam logic [1:0] PIN3_CODE = 2'h2;
    localparam logic [15:0] PRIO_RESET = 16'h0000;
    // ========================================================
    // system stack
    localparam int STACK_ENTRIES = 15;
    localparam int STACK_WIDTH = 32;
    // ========================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_PRESENT = 2'h1
    } disp_state_t;
    typedef struct packed {
        logic codec;
        logic [1:0] timer;      // bit0 overflow, bit1 compare
        logic [3:0] serial1;    // rx exc, rx, tx exc, tx from bit0
        logic [3:0] serial0;
        logic [1:0] host_data;  // bit0 receive, bit1 transmit
        logic [1:0] host_dma;
        logic host_cmd;
    } periph_req_t;
endpackage : evec_pkg

// ===== rtl/exception_priority_vectoring.sv
// exception priority arbitration, vector dispatch and system stack
`timescale 1ns/1ps
module exception_priority_vectoring
    import evec_pkg::*;
#(
    parameter int STACK_DEPTH = STACK_ENTRIES,
    parameter int STACK_W = STACK_WIDTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] prio_write,
    input wire logic [15:0] prio_wdata,
    output logic [15:0] priority_config_reg,
    output logic [15:0] priority_config_reg_second,
    input wire logic core_mask_high,
    input wire logic core_mask_low,
    input wire logic ext_request_first_n,
    input wire logic ext_request_second_n,
    input wire logic ext_request_third_n,
    input wire periph_req_t periph_req,
    input wire logic [5:0] host_cmd_slot,
    input wire logic illegal_instr,
    input wire logic software_trap,
    input wire logic instr_boundary,
    output logic vector_valid,
    output logic [15:0] vector_addr,
    output logic [4:0] dispatch_src,
    output logic dispatch_level3,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [STACK_W-1:0] stack_wdata,
    output logic [STACK_W-1:0] stack_rdata,
    output logic stack_full,
    output logic stack_empty
);
    // ========================================================
    // configuration, pins and pending state
    disp_state_t state, next_state;
    logic [15:0] cfg1, cfg2, next_cfg1, next_cfg2;
    logic [2:0] pin_prev, next_pin_prev, edge_hold, next_edge_hold;
    logic [3:0] l3_pend, next_l3_pend;  // reset, illegal, stack, trap
    logic [15:0] next_vector_addr;
    logic [4:0] next_dispatch_src;
    logic next_dispatch_level3;
    logic [NSRC-1:0] req;
    logic [1:0] code [NSRC];
    logic [1:0] mask, best_code;
    logic [4:0] best;
    logic found, take, stack_err;
    logic [2:0] pins, trig, fall;

    assign mask = {core_mask_high, core_mask_low};
    assign pins = {ext_request_third_n, ext_request_second_n,
                   ext_request_first_n};
    assign trig = {cfg2[F_PIN3_TRIG], cfg1[F_PIN2_TRIG], cfg1[F_PIN1_TRIG]};
    assign fall = pin_prev & ~pins;

    always_comb begin
        next_cfg1 = prio_write[0] ? prio_wdata : cfg1;
        next_cfg2 = prio_write[1] ? prio_wdata : cfg2;
        next_pin_prev = pins;
        // each edge-mode pin is sampled as its trigger bit says
        for (int p = 0; p < 3; p++) begin
            req[p] = trig[p] ? edge_hold[p] : ~pins[p];
        end
        req[18:3] = {periph_req.codec, periph_req.timer, periph_req.serial1,
                     periph_req.serial0, periph_req.host_data,
                     periph_req.host_dma, periph_req.host_cmd};
        // field code 00 off, code-1 is the level
        code[0] = cfg1[F_PIN1_LVL +: 2];
        code[1] = cfg1[F_PIN2_LVL +: 2];
        code[2] = cfg2[F_PIN3_EN] ? PIN3_CODE : 2'h0;
        for (int i = 3; i < 8; i++) code[i] = cfg1[F_HOST_LVL +: 2];
        for (int i = 8; i < 12; i++) code[i] = cfg1[F_SER0_LVL +: 2];
        for (int i = 12; i < 16; i++) code[i] = cfg1[F_SER1_LVL +: 2];
        for (int i = 16; i < 18; i++) code[i] = cfg1[F_TMR_LVL +: 2];
        code[18] = cfg2[F_CODEC_LVL +: 2];
        // descending scan with >= lets the lower index win ties
        found = 1'b0;
        best = 5'h00;
        best_code = 2'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i] && code[i] > mask &&
                (!found || code[i] >= best_code)) begin
                found = 1'b1;
                best = 5'(i);
                best_code = code[i];
            end
        end
        take = (state == ST_IDLE) && instr_boundary &&
               (found || (l3_pend != 4'h0));
        next_state = take ? ST_PRESENT : ST_IDLE;
        next_vector_addr = vector_addr;
        next_dispatch_src = dispatch_src;
        next_dispatch_level3 = dispatch_level3;
        next_l3_pend = l3_pend |
            {software_trap, stack_err, illegal_instr, 1'b0};
        next_edge_hold = edge_hold;
        if (take) begin
            next_dispatch_level3 = (l3_pend != 4'h0);
            next_dispatch_src = 5'h00;
            // fixed level-3 order; slot 0006 has no source at all
            if (l3_pend[0]) begin
                next_vector_addr = VEC_RESET;
                next_l3_pend[0] = 1'b0;
            end else if (l3_pend[1]) begin
                next_vector_addr = VEC_ILLEGAL;
                next_l3_pend[1] = illegal_instr;
            end else if (l3_pend[2]) begin
                next_vector_addr = VEC_STACK_ERR;
                next_l3_pend[2] = stack_err;
            end else if (l3_pend[3]) begin
                next_vector_addr = VEC_SW_TRAP;
                next_l3_pend[3] = software_trap;
            end else begin
                next_dispatch_src = best;
                next_vector_addr = VEC_TABLE[best];
                if (best == SRC_HOST_CMD &&
                    host_cmd_slot >= HC_ALT_FIRST) begin
                    next_vector_addr = {9'h000, host_cmd_slot, 1'b0};
                end
                if (best < 5'h03) begin
                    next_edge_hold[best[1:0]] = 1'b0;
                end
            end
        end
        // a fresh edge beats the clear of the same cycle
        next_edge_hold = next_edge_hold | (fall & trig);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cfg1 <= PRIO_RESET;
            cfg2 <= PRIO_RESET;
            pin_prev <= 3'h7;
            edge_hold <= 3'h0;
            l3_pend <= 4'h1;
            vector_addr <= VEC_RESET;
            dispatch_src <= 5'h00;
            dispatch_level3 <= 1'b0;
        end else begin
            state <= next_state;
            cfg1 <= next_cfg1;
            cfg2 <= next_cfg2;
            pin_prev <= next_pin_prev;
            edge_hold <= next_edge_hold;
            l3_pend <= next_l3_pend;
            vector_addr <= next_vector_addr;
            dispatch_src <= next_dispatch_src;
            dispatch_level3 <= next_dispatch_level3;
        end
    end

    assign vector_valid = (state == ST_PRESENT);
    assign priority_config_reg = cfg1;
    assign priority_config_reg_second = cfg2;

    // ========================================================
    // system stack
    logic [STACK_W-1:0] mem [STACK_DEPTH];
    logic [STACK_W-1:0] next_mem [STACK_DEPTH];
    logic [STACK_W-1:0] next_stack_rdata;
    logic [3:0] depth, next_depth;

    assign stack_full = (depth == 4'(STACK_DEPTH));
    assign stack_empty = (depth == 4'h0);
    assign stack_err = (stack_push && stack_full) ||
                       (stack_pop && stack_empty);

    always_comb begin
        next_mem = mem;
        next_depth = depth;
        next_stack_rdata = stack_rdata;
        // a refused push or pop leaves the contents untouched
        if (stack_push && !stack_full) begin
            next_mem[depth] = stack_wdata;
            next_depth = depth + 4'h1;
        end else if (stack_pop && !stack_empty) begin
            next_stack_rdata = mem[depth - 4'h1];
            next_depth = depth - 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            depth <= 4'h0;
            stack_rdata <= '0;
            for (int k = 0; k < STACK_DEPTH; k++) mem[k] <= '0;
        end else begin
            depth <= next_depth;
            stack_rdata <= next_stack_rdata;
            mem <= next_mem;
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_take_l3;
        (state == ST_IDLE) && instr_boundary && (l3_pend != 4'h0);
    endsequence
    chk_level3_never_masked: assert property (s_take_l3 |=>
        vector_valid && dispatch_level3) else $error("level 3 lost");
    chk_reset_served_first: assert property ((s_take_l3 and l3_pend[0])
        |=> vector_addr == VEC_RESET) else $error("reset not first");
    chk_mask_honoured: assert property (vector_valid && !dispatch_level3
        |-> code[dispatch_src] > $past(mask)) else $error("masked taken");
    chk_no_reserved: assert property (vector_valid
        |-> vector_addr != VEC_RESERVED) else $error("reserved raised");
    chk_serial_vector: assert property (vector_valid && !dispatch_level3
        && dispatch_src == 5'h08 |-> vector_addr == 16'h0010)
        else $error("serial vector wrong");
    chk_present_pulse: assert property (vector_valid |=> !vector_valid)
        else $error("vector held");
    chk_stack_error: assert property (stack_push && stack_full
        |=> ##[0:2] vector_valid || l3_pend[2]) else $error("no stack err");
    chk_stack_bound: assert property (depth <= 4'(STACK_DEPTH))
        else $error("stack overrun");
    chk_edge_latch: assert property (fall[0] && trig[0]
        |=> edge_hold[0] || (vector_valid && dispatch_src == 5'h00))
        else $error("edge lost");
endmodule : exception_priority_vectoring

// ===== verification/core_model.sv
// core sequencer model that offers instruction boundaries to the block
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic slow,
    output logic instr_boundary
);
    // ========================================================
    // boundaries
    // slow mode gives a boundary every other cycle, the way a core does
    // while it runs multi-cycle instructions
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_boundary <= 1'b0;
        end else begin
            instr_boundary <= run & (~slow | ~instr_boundary);
        end
    end
endmodule : core_model

// ===== verification/testbench.sv
// self-checking bench for exception priority and vector dispatch
`timescale 1ns/1ps
module testbench
    import evec_pkg::*;
();
    // ========================================================
    // signals
    logic clk = 0, rst_n = 0, run = 0, slow = 0, mhi = 0, mlo = 0;
    logic [1:0] prio_write = 2'h0;
    logic [15:0] prio_wdata = 16'h0000, cfg1, cfg2, vaddr;
    logic req1_n = 1, req2_n = 1, req3_n = 1, illegal = 0, trap = 0;
    periph_req_t periph = '0;
    logic [5:0] slot = 6'h00;
    logic boundary, vvalid, lvl3, push = 0, pop = 0, full, empty;
    logic [4:0] src;
    logic [31:0] wdata = 32'h0, rdata;
    int num_errors = 0, check_count = 0, cycles = 0;
    localparam logic [15:0] EXP_VEC [16] = '{16'h002C, 16'h0024,
        16'h0026, 16'h0028, 16'h002A, 16'h0010, 16'h0012, 16'h0014,
        16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0020,
        16'h0022, 16'h002E};
    always #12.5 clk = ~clk;
    core_model core_model_i (.clk(clk), .rst_n(rst_n), .run(run),
        .slow(slow), .instr_boundary(boundary));
    exception_priority_vectoring exception_priority_vectoring_i (
        .clk(clk), .rst_n(rst_n), .prio_write(prio_write),
        .prio_wdata(prio_wdata), .priority_config_reg(cfg1),
        .priority_config_reg_second(cfg2), .core_mask_high(mhi),
        .core_mask_low(mlo), .ext_request_first_n(req1_n),
        .ext_request_second_n(req2_n), .ext_request_third_n(req3_n),
        .periph_req(periph), .host_cmd_slot(slot),
        .illegal_instr(illegal), .software_trap(trap),
        .instr_boundary(boundary), .vector_valid(vvalid),
        .vector_addr(vaddr), .dispatch_src(src), .dispatch_level3(lvl3),
        .stack_push(push), .stack_pop(pop), .stack_wdata(wdata),
        .stack_rdata(rdata), .stack_full(full), .stack_empty(empty));
    // ========================================================
    // shared tasks
    task automatic report_and_stop();
        $display("counts: errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic write_cfg(input logic [1:0] sel, input logic [15:0] d);
        prio_write = sel;
        prio_wdata = d;
        tick(1);
        prio_write = 2'h0;
    endtask : write_cfg
    // requests are dropped as soon as the vector shows, as a source would
    task automatic expect_vec(input string name, input logic [15:0] exp);
        for (int i = 0; i < 20 && vvalid !== 1'b1; i++) tick(1);
        check("vector_valid", 32'h1, {31'h0, vvalid});
        check(name, {16'h0, exp}, {16'h0, vaddr});
        req1_n = 1;
        req2_n = 1;
        req3_n = 1;
        periph = '0;
        tick(1);
    endtask : expect_vec
    task automatic no_vec(input string name);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            if (vvalid !== 1'b0) seen = 1'b1;
        end
        check(name, 32'h0, {31'h0, seen});
        req1_n = 1;
        req3_n = 1;
        tick(2);
    endtask : no_vec
    // ========================================================
    // scenarios
    task automatic t_mask();
        for (int m = 0; m < 4; m++) begin
            {mhi, mlo} = 2'(m);
            req1_n = 0;
            if (m < 3) expect_vec("level2 permitted", 16'h000A);
            else no_vec("level2 under mask 11");
        end
        trap = 1;
        tick(1);
        trap = 0;
        expect_vec("trap under mask 11", 16'h0008);
        check("level3 flag", 32'h1, {31'h0, lvl3});
        write_cfg(2'h1, 16'hFF19);
        {mhi, mlo} = 2'h1;
        req1_n = 0;
        no_vec("level0 under mask 01");
        {mhi, mlo} = 2'h0;
        req1_n = 0;
        expect_vec("level0 under mask 00", 16'h000A);
        write_cfg(2'h1, 16'hFF1B);
    endtask : t_mask
    task automatic t_level3();
        illegal = 1;
        trap = 1;
        tick(1);
        illegal = 0;
        trap = 0;
        expect_vec("illegal first", 16'h0002);
        expect_vec("trap second", 16'h0008);
    endtask : t_level3
    task automatic t_vectors();
        slow = 1;
        for (int b = 0; b < 16; b++) begin
            periph = periph_req_t'(16'h0001 << b);
            expect_vec("periph vector", EXP_VEC[b]);
            check("dispatch src", 32'(b + 3), {27'h0, src});
        end
        slow = 0;
        foreach (EXP_VEC[k]) begin
            if (k == 0) continue;
            // the last pass steps just below the alternative range
            slot = (k == 15) ? 6'h17 : 6'h18 + 6'(k - 1) * 6'h3;
            periph.host_cmd = 1;
            if (k == 15) expect_vec("host below alt", 16'h002C);
            else expect_vec("host alt slot", {9'h0, slot, 1'b0});
        end
        slot = 6'h3F;
        periph.host_cmd = 1;
        expect_vec("host last slot", 16'h007E);
        slot = 6'h00;
    endtask : t_vectors
    task automatic t_ties();
        req1_n = 0;
        periph = periph_req_t'(16'h6001);
        expect_vec("pin beats host", 16'h000A);
        check("level3 flag maskable", 32'h0, {31'h0, lvl3});
        periph = periph_req_t'(16'h0021);
        expect_vec("host beats serial", 16'h002C);
        periph = periph_req_t'(16'h2020);
        expect_vec("serial beats timer", 16'h0010);
        write_cfg(2'h1, 16'hFF3B);
        req2_n = 0;
        tick(1);
        req2_n = 1;
        expect_vec("falling edge latched", 16'h000C);
        write_cfg(2'h2, 16'h0013);
        {mhi, mlo} = 2'h2;
        req3_n = 0;
        no_vec("third pin under mask 10");
        {mhi, mlo} = 2'h0;
        req3_n = 0;
        expect_vec("third pin level", 16'h000E);
        write_cfg(2'h2, 16'h0033);
        req3_n = 0;
        tick(1);
        req3_n = 1;
        expect_vec("third pin edge", 16'h000E);
    endtask : t_ties
    task automatic t_stack();
        push = 1;
        for (int i = 0; i < 15; i++) begin
            wdata = 32'hA5A50000 + 32'(i);
            tick(1);
        end
        check("stack full", 32'h1, {31'h0, full});
        tick(1);
        push = 0;
        expect_vec("push on full", 16'h0004);
        pop = 1;
        for (int i = 14; i >= 0; i--) begin
            tick(1);
            check("pop data", 32'hA5A50000 + 32'(i), rdata);
        end
        pop = 0;
        check("stack empty", 32'h1, {31'h0, empty});
        pop = 1;
        tick(1);
        pop = 0;
        expect_vec("pop on empty", 16'h0004);
    endtask : t_stack
    // ========================================================
    // sequence and hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        check("cfg1 reset", 32'h0, {16'h0, cfg1});
        check("cfg2 reset", 32'h0, {16'h0, cfg2});
        run = 1;
        expect_vec("reset vector", 16'h0000);
        write_cfg(2'h1, 16'hFF1B);
        write_cfg(2'h2, 16'h0003);
        check("cfg1 readback", 32'hFF1B, {16'h0, cfg1});
        check("cfg2 readback", 32'h0003, {16'h0, cfg2});
        t_mask();
        t_level3();
        t_vectors();
        t_ties();
        t_stack();
        report_and_stop();
    end
endmodule : testbench
